/* rtl/cswc_apb_regs.sv */
// apb slave holding the control register and showing sleep status
// assumes zero-wait-state apb; unmapped addresses answer with pslverr
`timescale 1ns/10ps
module cswc_apb_regs #(
  parameter int ADDR_W = 12 // apb address width
) (
  input  wire logic              ref_clk, // core clock
  input  wire logic              rst_b,   // async reset, active low
  input  wire logic              psel,    // apb select
  input  wire logic              penable, // apb access phase
  input  wire logic              pwrite,  // apb direction
  input  wire logic [ADDR_W-1:0] paddr,   // apb byte address
  input  wire logic [31:0]       pwdata,  // apb write data
  output logic      [31:0]       prdata,  // apb read data
  output logic                   pready,  // apb ready
  output logic                   pslverr, // apb error
  cswc_ctl_if.regs               ctl      // control and status bundle
);
  import cswc_pkg::*;

  // refuse address widths that the 12-bit offset compare cannot serve
  if (ADDR_W < 3 || ADDR_W > 12) begin : g_bad_addr_w
    $error("cswc_apb_regs: ADDR_W must be 3..12");
  end

  logic [11:0] addr_w;   // address widened to offset width
  logic        hit_ctl;  // control register addressed
  logic        hit_stat; // status register addressed
  logic [31:0] ctl_q;    // control register contents
  logic [31:0] rd_d;     // read mux

  assign addr_w = 12'(paddr);

  // address decode
  always_comb begin
    hit_ctl  = 1'b0;
    hit_stat = 1'b0;
    if (addr_w == CSWC_CTL_OFFSET) begin
      hit_ctl = 1'b1;
    end else if (addr_w == CSWC_STATUS_OFFSET) begin
      hit_stat = 1'b1;
    end
  end

  // zero wait states; error on unmapped addresses during access
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit_ctl & ~hit_stat;

  // control register write; reserved bits stay zero
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_q <= CSWC_CTL_RESET;
    end else if (psel && penable && pwrite && hit_ctl) begin
      ctl_q                <= 32'h0000_0000;
      ctl_q[CSWC_SAH_BIT]  <= pwdata[CSWC_SAH_BIT];
      ctl_q[CSWC_DEEP_BIT] <= pwdata[CSWC_DEEP_BIT];
      ctl_q[CSWC_EOP_BIT]  <= pwdata[CSWC_EOP_BIT];
    end
  end

  assign ctl.sleep_after_handler_ctl = ctl_q[CSWC_SAH_BIT];
  assign ctl.deep_sleep_select       = ctl_q[CSWC_DEEP_BIT];
  assign ctl.event_on_pending_ctl    = ctl_q[CSWC_EOP_BIT];

  // read mux; the event latch has no path here
  always_comb begin
    rd_d = 32'h0000_0000;
    if (hit_ctl) begin
      rd_d = ctl_q;
    end else if (hit_stat) begin
      rd_d[CSWC_ST_SLEEP_BIT]                    = ctl.sleeping;
      rd_d[CSWC_ST_DEEP_BIT]                     = ctl.deep_active;
      rd_d[CSWC_ST_STATE_LSB+1:CSWC_ST_STATE_LSB] = ctl.state;
      rd_d[CSWC_ST_SPUR_BIT]                     = ctl.spurious_wake;
    end
  end

  // read data captured in the setup cycle, valid through the access phase
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= CSWC_RDATA_RESET;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_d;
    end
  end
endmodule // cswc_apb_regs

/* rtl/cswc_event_latch.sv */
// one-bit event latch with set winning over clear
// assumes set and clear are single-cycle requests on ref_clk
`timescale 1ns/10ps
module cswc_event_latch (
  input  wire logic ref_clk, // core clock
  input  wire logic rst_b,   // async reset, active low
  input  wire logic set_req, // hardware event seen
  input  wire logic clr_req, // event consumed
  output logic      evt_q    // latch value
);
  import cswc_pkg::*;

  // set wins so that an event arriving while the latch is consumed is kept
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      evt_q <= CSWC_LATCH_RESET;
    end else if (set_req) begin
      evt_q <= 1'b1;
    end else if (clr_req) begin
      evt_q <= 1'b0;
    end
  end
endmodule // cswc_event_latch

/* rtl/cswc_top.sv */
// sleep entry and wakeup sequencer for a small processor core
// assumes instruction strobes are one-cycle pulses from the core pipeline on ref_clk
`timescale 1ns/10ps
module cswc_top #(
  parameter int ADDR_W = 12 // apb address width
) (
  input  wire logic                     ref_clk,                  // core clock, 200 mhz
  input  wire logic                     rst_b,                    // async reset, active low
  input  wire logic                     psel,                     // apb select
  input  wire logic                     penable,                  // apb access phase
  input  wire logic                     pwrite,                   // apb direction
  input  wire logic [ADDR_W-1:0]        paddr,                    // apb byte address
  input  wire logic [31:0]              pwdata,                   // apb write data
  output logic      [31:0]              prdata,                   // apb read data
  output logic                          pready,                   // apb ready
  output logic                          pslverr,                  // apb error
  input  wire logic                     wait_for_interrupt_instr, // interrupt wait, pulse
  input  wire logic                     wait_for_event_instr,     // event wait, pulse
  input  wire logic                     send_event_instr,         // local send-event, pulse
  input  wire logic                     remote_send_event,        // other cpu send-event
  input  wire logic                     ext_event,                // external event input
  input  wire logic                     handler_return_thread,    // return to thread, pulse
  input  wire logic                     exc_entry_req,            // exception can enter
  input  wire logic                     irq_above_prio,           // enabled higher irq pending
  input  wire logic                     interrupt_mask_bit,       // core interrupt mask
  input  wire logic                     new_irq_pending,          // irq became pending, pulse
  input  wire logic                     debug_wake,               // system activity wake
  output logic                          issue_stop,               // core must not issue
  output logic                          evt_wait_skip,            // event wait ends, no sleep
  output logic                          handler_hold,             // wake but hold handler
  output logic                          core_clk_stop,            // ordinary sleep clock stop
  output logic                          deep_sleep_req,           // deep sleep request
  output logic                          send_event_out,           // send-event to others
  output logic                          wake_pulse,               // core woke, one cycle
  output cswc_pkg::cswc_state_type      sleep_state               // sleep state code
);
  import cswc_pkg::*;

  // refuse address widths the register slave cannot decode
  if (ADDR_W < 3 || ADDR_W > 12) begin : g_bad_addr_w
    $error("cswc_top: ADDR_W must be 3..12");
  end

  cswc_ctl_if ctl (); // control and status bundle

  cswc_state_type state_q;      // sleep state
  cswc_state_type state_d;      // next sleep state
  logic           evt_q;        // event latch
  logic           evt_set;      // latch set request
  logic           evt_clr;      // latch clear request
  logic           pend_evt;     // pending irq raises an event
  logic           wake_irq;     // wake cause for interrupt-type sleep
  logic           wake_evt;     // wake cause for event sleep
  logic           wake_now;     // leaving sleep this cycle
  logic           deep_q;       // current sleep is deep
  logic           spur_q;       // last wake was spurious
  logic           clk_stop_q;   // registered clock stop
  logic           deep_req_q;   // registered deep request
  logic           wake_q;       // registered wake pulse
  logic           send_q;       // registered send-event output

  // register slave; the latch is deliberately not wired to it
  cswc_apb_regs #(
    .ADDR_W (ADDR_W)
  ) u_regs (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .ctl     (ctl.regs)
  );

  // event sources; while asleep on an event wait they wake directly instead
  assign pend_evt = ctl.event_on_pending_ctl & new_irq_pending;
  assign evt_set  = (ext_event | remote_send_event | pend_evt)
                  & (state_q != CSWC_ST_EVNT);
  // latch consumed by a skipped event wait, or by a wake from event sleep
  assign evt_clr  = ((state_q == CSWC_ST_RUN) & wait_for_event_instr
                     & ~wait_for_interrupt_instr & evt_q)
                  | ((state_q == CSWC_ST_EVNT) & wake_evt);

  cswc_event_latch u_latch (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .set_req (evt_set),
    .clr_req (evt_clr),
    .evt_q   (evt_q)
  );

  // wake causes; mask set still wakes on an enabled higher irq
  assign wake_irq = exc_entry_req | (interrupt_mask_bit & irq_above_prio)
                  | debug_wake;
  assign wake_evt = wake_irq | ext_event | remote_send_event | pend_evt
                  | evt_q;

  // next state of the sleep sequencer
  always_comb begin
    state_d  = state_q;
    wake_now = 1'b0;
    case (state_q)
      CSWC_ST_RUN: begin
        if (wait_for_interrupt_instr) begin
          state_d = CSWC_ST_INTR;
        end else if (wait_for_event_instr && !evt_q) begin
          state_d = CSWC_ST_EVNT;
        end else if (handler_return_thread && ctl.sleep_after_handler_ctl) begin
          state_d = CSWC_ST_EXIT;
        end
      end
      CSWC_ST_INTR, CSWC_ST_EXIT: begin
        if (wake_irq) begin
          state_d  = CSWC_ST_RUN;
          wake_now = 1'b1;
        end
      end
      CSWC_ST_EVNT: begin
        if (wake_evt) begin
          state_d  = CSWC_ST_RUN;
          wake_now = 1'b1;
        end
      end
      default: begin
        state_d = CSWC_ST_RUN;
      end
    endcase
  end

  // sleep state register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= CSWC_ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // sleep depth captured at entry and held through the sleep
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      deep_q <= 1'b0;
    end else if (state_q == CSWC_ST_RUN && state_d != CSWC_ST_RUN) begin
      deep_q <= ctl.deep_sleep_select;
    end
  end

  // power outputs follow the next state so they line up with it
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_stop_q <= 1'b0;
      deep_req_q <= 1'b0;
    end else if (state_d == CSWC_ST_RUN) begin
      clk_stop_q <= 1'b0;
      deep_req_q <= 1'b0;
    end else if (state_q == CSWC_ST_RUN) begin
      clk_stop_q <= ~ctl.deep_sleep_select;
      deep_req_q <= ctl.deep_sleep_select;
    end
  end

  // wake pulse and spurious-wake flag
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_q <= 1'b0;
      spur_q <= 1'b0;
    end else begin
      wake_q <= wake_now;
      if (wake_now) begin
        spur_q <= debug_wake & ~exc_entry_req & ~irq_above_prio;
      end
    end
  end

  // local send-event goes out to the other processors
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      send_q <= 1'b0;
    end else begin
      send_q <= send_event_instr;
    end
  end

  // outputs
  assign issue_stop     = (state_q != CSWC_ST_RUN);
  assign evt_wait_skip  = (state_q == CSWC_ST_RUN) & wait_for_event_instr
                        & ~wait_for_interrupt_instr & evt_q;
  assign handler_hold   = interrupt_mask_bit & irq_above_prio;
  assign core_clk_stop  = clk_stop_q;
  assign deep_sleep_req = deep_req_q;
  assign send_event_out = send_q;
  assign wake_pulse     = wake_q;
  assign sleep_state    = state_q;

  // status toward the register slave
  assign ctl.sleeping      = (state_q != CSWC_ST_RUN);
  assign ctl.deep_active   = deep_q & (state_q != CSWC_ST_RUN);
  assign ctl.state         = state_q;
  assign ctl.spurious_wake = spur_q;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  chk_intr_wait_sleeps: assert property (
    state_q == CSWC_ST_RUN && wait_for_interrupt_instr |=> state_q == CSWC_ST_INTR && issue_stop)
    else $error("interrupt wait did not enter sleep");
  chk_evt_wait_sleeps: assert property (
    state_q == CSWC_ST_RUN && wait_for_event_instr && !wait_for_interrupt_instr && !evt_q
    |=> state_q == CSWC_ST_EVNT)
    else $error("event wait with clear latch did not sleep");
  chk_skip_clears_latch: assert property (
    evt_wait_skip && !evt_set |=> state_q == CSWC_ST_RUN && !evt_q)
    else $error("event wait with set latch did not continue and clear");
  chk_apb_latch_free: assert property (
    psel && penable && pwrite && !evt_set && !evt_clr |=> $stable(evt_q))
    else $error("register write changed the event latch");
  chk_event_sets_latch: assert property (
    (ext_event || remote_send_event) && state_q != CSWC_ST_EVNT |=> evt_q)
    else $error("event did not set the latch");
  chk_awake_event_latch: assert property (
    state_q == CSWC_ST_RUN && ext_event
    ##1 state_q == CSWC_ST_RUN && wait_for_event_instr && !wait_for_interrupt_instr
    |=> state_q == CSWC_ST_RUN)
    else $error("event wait slept after an earlier event");
  chk_exit_sleep: assert property (
    state_q == CSWC_ST_RUN && handler_return_thread && ctl.sleep_after_handler_ctl
    && !wait_for_interrupt_instr && !wait_for_event_instr |=> state_q == CSWC_ST_EXIT)
    else $error("sleep after handler not entered");
  chk_intr_holds_sleep: assert property (
    (state_q == CSWC_ST_INTR || state_q == CSWC_ST_EXIT) && !wake_irq |=> $stable(state_q))
    else $error("interrupt sleep left without cause");
  chk_mask_wake_hold: assert property (
    state_q == CSWC_ST_INTR && interrupt_mask_bit && irq_above_prio
    |-> handler_hold ##1 state_q == CSWC_ST_RUN ##0 wake_pulse)
    else $error("masked interrupt did not wake with handler held");
  chk_evt_sleep_wakes: assert property (
    state_q == CSWC_ST_EVNT && (ext_event || remote_send_event || exc_entry_req)
    |=> state_q == CSWC_ST_RUN && !evt_q)
    else $error("event sleep did not wake");
  chk_pending_wakes: assert property (
    state_q == CSWC_ST_EVNT && ctl.event_on_pending_ctl && new_irq_pending
    |=> state_q == CSWC_ST_RUN)
    else $error("pending interrupt did not wake");
  chk_debug_wake: assert property (
    state_q != CSWC_ST_RUN && debug_wake
    |=> state_q == CSWC_ST_RUN ##0 spur_q == !$past(exc_entry_req || irq_above_prio))
    else $error("system activity did not wake");
  chk_sleep_depth: assert property (
    state_q == CSWC_ST_RUN && wait_for_interrupt_instr
    |=> deep_sleep_req == $past(ctl.deep_sleep_select) && core_clk_stop != deep_sleep_req)
    else $error("sleep depth not taken from select");
  chk_power_exclusive: assert property (
    state_q == CSWC_ST_RUN |-> !core_clk_stop && !deep_sleep_req)
    else $error("power request while running");
  chk_reset_latch: assert property (
    $rose(rst_b) |-> !evt_q)
    else $error("event latch not clear after reset");

  cov_intr_round: cover property (state_q == CSWC_ST_INTR ##[1:20] wake_pulse);
  cov_evt_wake: cover property (state_q == CSWC_ST_EVNT && ext_event);
  cov_evt_skipped: cover property (evt_wait_skip);
  cov_exit_deep: cover property (state_q == CSWC_ST_EXIT && deep_sleep_req);

endmodule // cswc_top

/* shared/cswc_ctl_if.sv */
// control and status bundle between the register slave and the sleep sequencer
// assumes both ends run on ref_clk
`timescale 1ns/10ps
interface cswc_ctl_if;
  logic                      sleep_after_handler_ctl; // sleep when handler returns to thread
  logic                      deep_sleep_select;       // sleep entries go deep
  logic                      event_on_pending_ctl;    // new pending interrupt raises event
  logic                      sleeping;                // core asleep now
  logic                      deep_active;             // current sleep is deep
  cswc_pkg::cswc_state_type  state;                   // sleep state code
  logic                      spurious_wake;           // last wake from system activity

  // register side drives the controls and reads the status
  modport regs (output sleep_after_handler_ctl, output deep_sleep_select,
                output event_on_pending_ctl, input sleeping, input deep_active,
                input state, input spurious_wake);
  // sequencer side reads the controls and drives the status
  modport core (input sleep_after_handler_ctl, input deep_sleep_select,
                input event_on_pending_ctl, output sleeping, output deep_active,
                output state, output spurious_wake);
endinterface // cswc_ctl_if

/* shared/cswc_pkg.sv */
// constants, register map and state codes for the sleep and wakeup control block
// assumes a 32-bit apb register bus and a single 200 mhz core clock
package cswc_pkg;

  // register byte offsets on the apb bus
  localparam logic [11:0] CSWC_CTL_OFFSET    = 12'h000; // system_control_reg
  localparam logic [11:0] CSWC_STATUS_OFFSET = 12'h004; // sleep status, read only

  // system_control_reg field positions
  localparam int CSWC_SAH_BIT  = 1; // sleep_after_handler_ctl
  localparam int CSWC_DEEP_BIT = 2; // deep_sleep_select
  localparam int CSWC_EOP_BIT  = 4; // event_on_pending_ctl

  // status register field positions
  localparam int CSWC_ST_SLEEP_BIT = 0; // asleep now
  localparam int CSWC_ST_DEEP_BIT  = 1; // current sleep is deep
  localparam int CSWC_ST_STATE_LSB = 2; // two-bit sleep state code
  localparam int CSWC_ST_SPUR_BIT  = 4; // last wake came from system activity

  // values after reset
  localparam logic [31:0] CSWC_CTL_RESET   = 32'h0000_0000;
  localparam logic        CSWC_LATCH_RESET = 1'b0;
  localparam logic [31:0] CSWC_RDATA_RESET = 32'h0000_0000;

  // sleep state machine
  typedef enum logic [1:0] {
    CSWC_ST_RUN  = 2'b00, // executing
    CSWC_ST_INTR = 2'b01, // asleep after wait_for_interrupt_instr
    CSWC_ST_EVNT = 2'b10, // asleep after wait_for_event_instr
    CSWC_ST_EXIT = 2'b11  // asleep after handler return to thread mode
  } cswc_state_type;

endpackage

/* tb/cswc_evt_partner.sv */
// far side model: peripherals and a second cpu raising event lines
// assumes kick requests arrive from the bench just after ref_clk edges
`timescale 1ns/10ps
module cswc_evt_partner (
  input  wire logic       ref_clk,           // core clock
  input  wire logic       rst_b,             // async reset, active low
  input  wire logic [3:0] kick,              // 0 ext, 1 remote sev, 2 new pend, 3 exception
  output logic            ext_event,         // external event line
  output logic            remote_send_event, // other cpu send-event
  output logic            new_irq_pending,   // irq became pending
  output logic            exc_entry_req      // exception can enter
);
  // each line rises for one cycle after its kick and is held low otherwise
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      {exc_entry_req, new_irq_pending, remote_send_event, ext_event} <= 4'h0;
    end else begin
      {exc_entry_req, new_irq_pending, remote_send_event, ext_event} <= kick;
    end
  end
endmodule // cswc_evt_partner

/* tb/cswc_top_tb.sv */
// self-checking bench for the sleep and wakeup sequencer
// assumes cswc_top with default address width and the event partner model
`timescale 1ns/10ps
module cswc_top_tb;
  import cswc_pkg::*;
  logic           ref_clk = 1'b0;                        // core clock
  logic           rst_b = 1'b0;                          // reset, active low
  logic           psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb controls
  logic [11:0]    paddr = 12'h000;                       // apb address
  logic [31:0]    pwdata = 32'h0, prdata, rd;            // apb data
  logic           pready, pslverr, er;                   // apb answer
  logic [3:0]     pls = 4'h0, kick = 4'h0;               // instr pulses, partner kicks
  logic           msk = 1'b0, above = 1'b0, dbg = 1'b0;  // mask, priority, debug wake
  logic           ext, rsev, npend, exc;                 // partner lines
  logic           stop, skip, hold, cstop, dreq, sevo, wk, skip_seen, lat, d; // outputs, model
  cswc_state_type st, xs;                                // sleep state, expected
  int             error_cnt = 0, n_checks = 0, i, k;     // counters
  int             seed = 32'heed77e3b;                   // fixed random seed

  // 200 mhz clock
  always #2.5 ref_clk = ~ref_clk;

  cswc_top DUT (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wait_for_interrupt_instr(pls[0]), .wait_for_event_instr(pls[1]),
    .send_event_instr(pls[3]), .remote_send_event(rsev), .ext_event(ext),
    .handler_return_thread(pls[2]), .exc_entry_req(exc), .irq_above_prio(above),
    .interrupt_mask_bit(msk), .new_irq_pending(npend), .debug_wake(dbg),
    .issue_stop(stop), .evt_wait_skip(skip), .handler_hold(hold), .core_clk_stop(cstop),
    .deep_sleep_req(dreq), .send_event_out(sevo), .wake_pulse(wk), .sleep_state(st));

  cswc_evt_partner partner (.ref_clk(ref_clk), .rst_b(rst_b), .kick(kick),
    .ext_event(ext), .remote_send_event(rsev), .new_irq_pending(npend),
    .exc_entry_req(exc));

  // compare and count
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one apb transfer, answer taken at the edge where pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dat);
    int n;
    @(posedge ref_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, dat};
    @(posedge ref_clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      error_cnt++;
      test_done();
    end
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask

  // one-cycle instruction pulse; skip flag sampled mid-pulse
  task automatic fire(input logic [3:0] v);
    @(posedge ref_clk);
    pls <= v;
    @(negedge ref_clk);
    skip_seen = skip;
    @(posedge ref_clk);
    pls <= 4'h0;
    #1;
  endtask

  // partner line for one cycle, then the edge that samples it
  task automatic wake(input logic [3:0] kv);
    @(posedge ref_clk);
    kick <= kv;
    @(posedge ref_clk);
    kick <= 4'h0;
    @(posedge ref_clk);
    #1;
  endtask

  // expected status word
  function automatic logic [31:0] stw(input logic s, input logic dp, input logic [1:0] c,
                                      input logic sp);
    return {27'h0, sp, c, dp, s};
  endfunction

  // expected state after an interrupt or event wait with a given latch value
  function automatic cswc_state_type exp_st(input logic is_intr, input logic l);
    if (is_intr) return CSWC_ST_INTR;
    return l ? CSWC_ST_RUN : CSWC_ST_EVNT;
  endfunction

  // hang guard
  initial begin
    #100000;
    error_cnt++;
    test_done();
  end

  // main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1;
    chk(st, CSWC_ST_RUN);
    apb(1'b1, CSWC_CTL_OFFSET, 32'hffff_ffff);
    apb(1'b0, CSWC_CTL_OFFSET, 32'h0);
    chk(rd, 32'h0000_0016);
    apb(1'b1, CSWC_STATUS_OFFSET, 32'hffff_ffff);
    apb(1'b0, CSWC_STATUS_OFFSET, 32'h0);
    chk(rd, stw(1'b0, 1'b0, 2'b00, 1'b0));
    apb(1'b0, 12'h008, 32'h0);
    chk({rd, er}, 33'h1);
    apb(1'b1, CSWC_CTL_OFFSET, 32'h0);
    fire(4'b0010);
    chk({st, stop, cstop}, {CSWC_ST_EVNT, 2'b11});
    wake(4'b0001);
    chk({st, wk}, {CSWC_ST_RUN, 1'b1});
    fire(4'b0010);
    wake(4'b0010);
    chk(st, CSWC_ST_RUN);
    wake(4'b0001);
    fire(4'b0010);
    chk({skip_seen, st}, {1'b1, CSWC_ST_RUN});
    fire(4'b0010);
    chk(st, CSWC_ST_EVNT);
    wake(4'b1000);
    chk(st, CSWC_ST_RUN);
    wake(4'b0010);
    fire(4'b1010);
    chk({skip_seen, sevo}, 2'b11);
    wake(4'b0001);
    fire(4'b0001);
    chk(st, CSWC_ST_INTR);
    wake(4'b0101);
    chk(st, CSWC_ST_INTR);
    wake(4'b1000);
    chk({st, wk}, {CSWC_ST_RUN, 1'b1});
    fire(4'b0010);
    chk(skip_seen, 1'b1);
    apb(1'b1, CSWC_CTL_OFFSET, 32'h4);
    fire(4'b0001);
    chk({dreq, cstop}, 2'b10);
    apb(1'b0, CSWC_STATUS_OFFSET, 32'h0);
    chk(rd, stw(1'b1, 1'b1, CSWC_ST_INTR, 1'b0));
    wake(4'b1000);
    chk(dreq, 1'b0);
    apb(1'b1, CSWC_CTL_OFFSET, 32'h2);
    fire(4'b0100);
    chk(st, CSWC_ST_EXIT);
    @(posedge ref_clk);
    dbg <= 1'b1;
    @(posedge ref_clk);
    dbg <= 1'b0;
    #1;
    chk(st, CSWC_ST_RUN);
    apb(1'b0, CSWC_STATUS_OFFSET, 32'h0);
    chk(rd, stw(1'b0, 1'b0, CSWC_ST_RUN, 1'b1));
    fire(4'b0001);
    @(posedge ref_clk);
    {msk, above} <= 2'b11;
    @(posedge ref_clk);
    #1;
    chk({st, hold}, {CSWC_ST_RUN, 1'b1});
    @(posedge ref_clk);
    {msk, above} <= 2'b00;
    apb(1'b1, CSWC_CTL_OFFSET, 32'h10);
    fire(4'b0010);
    wake(4'b0100);
    chk({st, hold}, {CSWC_ST_RUN, 1'b0});
    apb(1'b1, CSWC_CTL_OFFSET, 32'h0);
    fire(4'b0010);
    wake(4'b0100);
    chk(st, CSWC_ST_EVNT);
    wake(4'b1000);
    lat = 1'b0;
    for (i = 0; i < 24; i++) begin
      k = $random(seed);
      d = k[2];
      apb(1'b1, CSWC_CTL_OFFSET, {29'h0, d, 2'b00});
      if (k[0]) wake(4'b0001);
      lat = lat | k[0];
      xs = exp_st(k[1], lat);
      fire(k[1] ? 4'b0001 : 4'b0010);
      chk({st, dreq}, {xs, d & (xs != CSWC_ST_RUN)});
      if (!k[1]) lat = 1'b0;
      if (xs != CSWC_ST_RUN) wake(4'b1000);
    end
    test_done();
  end
endmodule // cswc_top_tb
